// file: core/cpa_pkg.sv
package cpa_pkg;
   localparam int PIX_W = 24;
   localparam int KEY_W = 40;
   localparam int KEY_ONES = 20;
   localparam int AUTH_CYCLES = 128;
   localparam int RESP_FRAMES = 128;
   localparam int ENH_FRAMES = 16;
   // Transmitter key vector, value is arbitrary
   localparam logic [39:0] TX_KEY = 40'h5a_a5c3_3c96;
   localparam logic [31:0] LFSR_SEED = 32'h0000_0001;
   // Register offsets (byte addresses)
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_KEY_LO = 8'h04;
   localparam logic [7:0] OFF_KEY_HI = 8'h08;
   localparam logic [7:0] OFF_RX_RESP = 8'h0c;
   localparam logic [7:0] OFF_TX_RESP = 8'h10;
   localparam logic [7:0] OFF_ENH = 8'h14;
   localparam logic [7:0] OFF_STATUS = 8'h18;
   localparam logic [7:0] OFF_INT_STAT = 8'h1c;
   localparam logic [7:0] OFF_INT_MASK = 8'h20;
   localparam logic [7:0] OFF_FRAME = 8'h24;
   // Control fields
   localparam int CTRL_INT_COMP = 0;
   localparam int CTRL_ENC_EN = 1;
   localparam int CTRL_PROT_RST = 2;
   localparam int CTRL_START = 3;
   // Interrupt event bits
   localparam int EV_RESP = 0;
   localparam int EV_ENH = 1;
   localparam int EV_CMP = 2;
   localparam int EV_KEY = 3;
   localparam int EV_W = 4;
   typedef enum logic [1:0] {AUTH_IDLE, AUTH_CALC, AUTH_DONE} cpa_auth_t;
   typedef struct packed {
      cpa_auth_t auth;
      logic [7:0] calc_cnt;
      logic int_comp;
      logic enc_en;
      logic enc_act;
      logic [39:0] key;
      logic [31:0] cipher;
      logic [15:0] tx_resp;
      logic [15:0] rx_resp;
      logic [7:0] tx_enh;
      logic [7:0] rx_enh;
      logic [6:0] frame_cnt;
      logic match;
      logic key_bad;
      logic enh_match;
      logic [3:0] stat;
      logic [3:0] mask;
      logic vs_d;
      logic hs_d;
      logic [31:0] rdata;
      logic [23:0] pix_out;
      logic irq;
   } cpa_state_t;
   typedef struct packed {
      logic [23:0] pix;
      logic vsync;
      logic hsync;
   } cpa_video_t;
endpackage

// file: core/cpa_auth_link_check.sv
// Summary of operation
// RULE_01 - Control bit one picks on-chip compare, zero picks host compare.
// RULE_02 - On-chip mode: written receiver response is compared with own, match flag set.
// RULE_03 - Host mode: own and receiver responses are readable for host comparison.
// RULE_04 - Receiver key vector valid only with exactly 20 ones; invalid flag reports it.
// RULE_05 - Host authenticates only with unrevoked key and matching responses.
// RULE_06 - Host resamples on mismatch, then writes protection reset if still failing.
// RULE_07 - Host sends no protected content when receiver key is revoked.
// RULE_08 - Host checks link integrity every 128 frames or about two seconds.
// RULE_09 - A fresh integrity response is produced every 128 frames.
// RULE_10 - An 8-bit enhanced response is produced every 16 frames.
// RULE_11 - Host waits for three enhanced mismatches in a row before resampling.
// RULE_12 - Encryption runs only while the enable bit is set.
// RULE_13 - Host writes enable at both ends within one vertical sync period.
// RULE_14 - Enable bit alone switches encryption, regardless of content.
// RULE_15 - Link carries plain data whenever encryption is not enabled.
// RULE_16 - A 16-bit initial response is computed from the cipher.
// RULE_17 - Cipher re-keys on every falling vertical and horizontal sync edge while encryption is active.
// RULE_18 - Host authenticates before enabling and disables before re-authenticating.
// RULE_19 - Protection reset clears match status and comparison state.
`timescale 1ns/10ps
module cpa_auth_link_check (
   input logic clk,
   input logic rst,
   input logic [7:0] addr,
   input logic [31:0] wdata,
   input logic wr,
   input logic rd,
   output logic [31:0] rdata,
   input cpa_pkg::cpa_video_t vid_in,
   output logic [23:0] pix_out,
   output logic enc_active,
   output logic irq
);
   function automatic logic [31:0] cpa_lfsr(input logic [31:0] c);
      cpa_lfsr = {c[30:0], c[31] ^ c[21] ^ c[1] ^ c[0]};
   endfunction

   function automatic logic [15:0] cpa_resp(input logic [31:0] c);
      cpa_resp = c[31:16] ^ c[15:0];
   endfunction

   function automatic logic [5:0] cpa_ones(input logic [39:0] k);
      logic [5:0] n;
      n = 6'h00;
      for (int i = 0; i < cpa_pkg::KEY_W; i++) begin
         n = n + {5'h00, k[i]};
      end
      cpa_ones = n;
   endfunction

   cpa_pkg::cpa_state_t st_q;
   cpa_pkg::cpa_state_t st_d;
   logic vs_fall;
   logic hs_fall;
   logic wr_ctrl;
   logic start_auth;
   logic prot_rst;
   logic [3:0] ev;

   assign vs_fall = st_q.vs_d & ~vid_in.vsync;
   assign hs_fall = st_q.hs_d & ~vid_in.hsync;
   assign wr_ctrl = wr && addr == cpa_pkg::OFF_CTRL;
   assign start_auth = wr_ctrl && wdata[cpa_pkg::CTRL_START];
   assign prot_rst = wr_ctrl && wdata[cpa_pkg::CTRL_PROT_RST];

   always_comb begin
      st_d = st_q;
      ev = 4'h0;
      st_d.vs_d = vid_in.vsync;
      st_d.hs_d = vid_in.hsync;
      // Cipher runs during response calculation and while encrypting
      if (st_q.auth == cpa_pkg::AUTH_CALC || st_q.enc_act) begin
         st_d.cipher = cpa_lfsr(st_q.cipher);
      end
      if (st_q.enc_act && (vs_fall || hs_fall)) begin
         st_d.cipher = cpa_lfsr(st_q.cipher ^ st_q.key[31:0]); // RULE_17
      end
      // Encryption state follows the enable bit at the frame boundary
      if (vs_fall) begin
         st_d.enc_act = st_q.enc_en; // RULE_12 RULE_14 RULE_13
      end
      // Initial response after the calculation window
      case (st_q.auth)
         cpa_pkg::AUTH_IDLE: begin
            st_d.calc_cnt = 8'h00;
         end
         cpa_pkg::AUTH_CALC: begin
            st_d.calc_cnt = st_q.calc_cnt + 8'h01;
            if (st_q.calc_cnt == 8'(cpa_pkg::AUTH_CYCLES - 1)) begin
               st_d.tx_resp = cpa_resp(st_q.cipher); // RULE_16
               st_d.auth = cpa_pkg::AUTH_DONE;
               ev[cpa_pkg::EV_RESP] = 1'b1;
            end
         end
         cpa_pkg::AUTH_DONE: begin
            st_d.calc_cnt = 8'h00;
         end
         default: begin
            st_d.auth = cpa_pkg::AUTH_IDLE;
         end
      endcase
      // Periodic integrity and enhanced responses, counted in encrypted frames
      if (vs_fall && st_q.enc_act) begin
         st_d.frame_cnt = st_q.frame_cnt + 7'h01;
         if (st_q.frame_cnt == 7'(cpa_pkg::RESP_FRAMES - 1)) begin
            st_d.tx_resp = cpa_resp(st_q.cipher); // RULE_09
            ev[cpa_pkg::EV_RESP] = 1'b1;
         end
         if (st_q.frame_cnt[3:0] == 4'(cpa_pkg::ENH_FRAMES - 1)) begin
            st_d.tx_enh = st_q.cipher[7:0] ^ st_q.cipher[23:16]; // RULE_10
            ev[cpa_pkg::EV_ENH] = 1'b1;
         end
      end
      // Register writes
      if (wr) begin
         case (addr)
            cpa_pkg::OFF_CTRL: begin
               st_d.int_comp = wdata[cpa_pkg::CTRL_INT_COMP]; // RULE_01
               st_d.enc_en = wdata[cpa_pkg::CTRL_ENC_EN];
            end
            cpa_pkg::OFF_KEY_LO: begin
               st_d.key[31:0] = wdata;
            end
            cpa_pkg::OFF_KEY_HI: begin
               st_d.key[39:32] = wdata[7:0];
            end
            cpa_pkg::OFF_RX_RESP: begin
               st_d.rx_resp = wdata[15:0];
               if (st_q.int_comp) begin
                  st_d.match = wdata[15:0] == st_q.tx_resp; // RULE_02
                  ev[cpa_pkg::EV_CMP] = 1'b1;
               end
            end
            cpa_pkg::OFF_ENH: begin
               st_d.rx_enh = wdata[15:8];
               if (st_q.int_comp) begin
                  st_d.enh_match = wdata[15:8] == st_q.tx_enh;
                  ev[cpa_pkg::EV_CMP] = 1'b1;
               end
            end
            cpa_pkg::OFF_INT_MASK: begin
               st_d.mask = wdata[3:0];
            end
            default: begin
            end
         endcase
      end
      // Key balance check on every key change
      st_d.key_bad = cpa_ones(st_d.key) != 6'(cpa_pkg::KEY_ONES); // RULE_04
      if (st_d.key_bad && !st_q.key_bad) begin
         ev[cpa_pkg::EV_KEY] = 1'b1;
      end
      if (start_auth) begin
         st_d.auth = cpa_pkg::AUTH_CALC;
         st_d.calc_cnt = 8'h00;
         st_d.cipher = st_q.key[31:0] ^ cpa_pkg::TX_KEY[31:0] ^ cpa_pkg::LFSR_SEED;
         st_d.match = 1'b0;
      end
      if (prot_rst) begin
         st_d.auth = cpa_pkg::AUTH_IDLE; // RULE_19
         st_d.match = 1'b0;
         st_d.enh_match = 1'b0;
         st_d.rx_resp = 16'h0000;
         st_d.rx_enh = 8'h00;
         st_d.tx_resp = 16'h0000;
         st_d.tx_enh = 8'h00;
         st_d.frame_cnt = 7'h00;
      end
      // Sticky status, a new event wins over a write-one clear
      if (wr && addr == cpa_pkg::OFF_INT_STAT) begin
         st_d.stat = st_q.stat & ~wdata[3:0];
      end
      st_d.stat = st_d.stat | ev;
      st_d.irq = |(st_d.stat & st_d.mask);
      // Link data: keystream mixed in only while encrypting
      if (st_q.enc_act) begin
         st_d.pix_out = vid_in.pix ^ st_q.cipher[23:0];
      end else begin
         st_d.pix_out = vid_in.pix; // RULE_15
      end
      // Register reads, data in the following cycle
      st_d.rdata = 32'h0000_0000;
      if (rd) begin
         case (addr)
            cpa_pkg::OFF_CTRL: st_d.rdata = {28'h0, 2'b00, st_q.enc_en, st_q.int_comp};
            cpa_pkg::OFF_KEY_LO: st_d.rdata = st_q.key[31:0];
            cpa_pkg::OFF_KEY_HI: st_d.rdata = {24'h0, st_q.key[39:32]};
            cpa_pkg::OFF_RX_RESP: st_d.rdata = {16'h0, st_q.rx_resp};
            cpa_pkg::OFF_TX_RESP: st_d.rdata = st_q.int_comp ? 32'h0 : {16'h0, st_q.tx_resp}; // RULE_03
            cpa_pkg::OFF_ENH: st_d.rdata = {16'h0, st_q.rx_enh, st_q.int_comp ? 8'h00 : st_q.tx_enh}; // RULE_03
            cpa_pkg::OFF_STATUS: st_d.rdata = {26'h0, st_q.enc_act, st_q.auth == cpa_pkg::AUTH_DONE,
                                               st_q.enh_match, st_q.key_bad, st_q.match, 1'b0};
            cpa_pkg::OFF_INT_STAT: st_d.rdata = {28'h0, st_q.stat};
            cpa_pkg::OFF_INT_MASK: st_d.rdata = {28'h0, st_q.mask};
            cpa_pkg::OFF_FRAME: st_d.rdata = {25'h0, st_q.frame_cnt};
            default: st_d.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= '0;
         st_q.key_bad <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   assign rdata = st_q.rdata;
   assign pix_out = st_q.pix_out;
   assign enc_active = st_q.enc_act;
   assign irq = st_q.irq;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence vs_fall_s;
      vid_in.vsync == 1'b0 && st_q.vs_d == 1'b1;
   endsequence

   sequence rx_write_s;
      wr && addr == cpa_pkg::OFF_RX_RESP;
   endsequence

   chk_int_match: assert property (rx_write_s and st_q.int_comp |=> // RULE_02
      st_q.match == ($past(wdata[15:0]) == $past(st_q.tx_resp)))
      else $error("Internal compare result wrong");
   chk_host_no_match: assert property (rx_write_s and !st_q.int_comp && !start_auth |=> // RULE_01
      $stable(st_q.match))
      else $error("Match flag changed in host compare mode");
   chk_key_balance: assert property ($changed(st_q.key) |-> // RULE_04
      st_q.key_bad == (cpa_ones(st_q.key) != 6'd20))
      else $error("Key balance flag wrong");
   chk_resp_period: assert property (vs_fall_s and st_q.enc_act && st_q.frame_cnt == 7'd127 && !prot_rst |=> // RULE_09
      st_q.stat[0] && st_q.tx_resp == cpa_resp($past(st_q.cipher)))
      else $error("Integrity response missing at frame 128");
   chk_enh_period: assert property (vs_fall_s and st_q.enc_act && st_q.frame_cnt[3:0] == 4'd15 && !prot_rst |=> // RULE_10
      st_q.stat[1] && st_q.tx_enh == ($past(st_q.cipher[7:0]) ^ $past(st_q.cipher[23:16])))
      else $error("Enhanced response missing at frame 16");

   sequence hs_fall_s;
      vid_in.hsync == 1'b0 && st_q.hs_d == 1'b1;
   endsequence

   sequence calc_end_s;
      st_q.auth == cpa_pkg::AUTH_CALC && st_q.calc_cnt == 8'(cpa_pkg::AUTH_CYCLES - 1);
   endsequence

   sequence calc_run_s;
      st_q.auth == cpa_pkg::AUTH_CALC && st_q.calc_cnt < 8'(cpa_pkg::AUTH_CYCLES - 1);
   endsequence

   sequence tx_read_s;
      rd && addr == cpa_pkg::OFF_TX_RESP;
   endsequence

   sequence enh_read_s;
      rd && addr == cpa_pkg::OFF_ENH;
   endsequence

   // Initial response window
   chk_auth_done: assert property (calc_end_s and !start_auth && !prot_rst |=> // RULE_16
      st_q.auth == cpa_pkg::AUTH_DONE && st_q.stat[cpa_pkg::EV_RESP] &&
      st_q.tx_resp == cpa_resp($past(st_q.cipher)))
      else $error("Initial response not ready after calculation window");
   chk_calc_hold: assert property (calc_run_s and !wr_ctrl |=> // RULE_16
      st_q.auth == cpa_pkg::AUTH_CALC && st_q.calc_cnt == 8'($past(st_q.calc_cnt) + 8'h01))
      else $error("Initial response calculation ended early");

   // Encryption path
   chk_enc_follow: assert property (vs_fall_s |=> // RULE_14
      st_q.enc_act == $past(st_q.enc_en))
      else $error("Encryption state does not follow the enable bit");
   chk_enc_hold: assert property (st_q.vs_d == 1'b0 || vid_in.vsync == 1'b1 |=> // RULE_12
      $stable(st_q.enc_act))
      else $error("Encryption state changed inside a frame");
   chk_enc_mix: assert property (st_q.enc_act |=> // RULE_12
      st_q.pix_out == ($past(vid_in.pix) ^ $past(st_q.cipher[23:0])))
      else $error("Encrypted pixel wrong");
   chk_plain_pass: assert property (!st_q.enc_act |=> // RULE_15
      st_q.pix_out == $past(vid_in.pix))
      else $error("Plain pixel altered");
   chk_rekey_line: assert property (hs_fall_s and st_q.enc_act && !start_auth |=> // RULE_17
      st_q.cipher == cpa_lfsr($past(st_q.cipher) ^ $past(st_q.key[31:0])))
      else $error("Cipher not re-keyed at line start");

   // Status, protection reset, host reads and frame counting
   chk_prot_clear: assert property (prot_rst |=> // RULE_19
      !st_q.match && !st_q.enh_match && st_q.auth == cpa_pkg::AUTH_IDLE && st_q.frame_cnt == 7'h00)
      else $error("Protection reset left comparison state");
   chk_stat_sticky: assert property (!(wr && addr == cpa_pkg::OFF_INT_STAT) |=>
      ($past(st_q.stat) & ~st_q.stat) == 4'h0)
      else $error("Status bit dropped without a clear");
   chk_host_read: assert property (tx_read_s and !st_q.int_comp |=> // RULE_03
      st_q.rdata == {16'h0000, $past(st_q.tx_resp)})
      else $error("Own response not readable in host mode");
   chk_enh_read: assert property (enh_read_s and !st_q.int_comp |=> // RULE_03
      st_q.rdata[7:0] == $past(st_q.tx_enh) && st_q.rdata[15:8] == $past(st_q.rx_enh))
      else $error("Enhanced responses not readable in host mode");
   chk_frame_step: assert property (vs_fall_s and st_q.enc_act && !prot_rst |=> // RULE_09
      st_q.frame_cnt == 7'($past(st_q.frame_cnt) + 7'h01))
      else $error("Encrypted frame not counted");
endmodule // cpa_auth_link_check

// file: sim/cpa_video_src.sv
`timescale 1ns/10ps
module cpa_video_src (
   input logic clk,
   input logic rst,
   output cpa_pkg::cpa_video_t vid
);
   logic [4:0] cnt;
   // Frames of 32 clocks, sync pulses for frame and line
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt <= 5'h0;
         vid <= '0;
      end else begin
         cnt <= cnt + 5'h1;
         vid.pix <= 24'($urandom);
         vid.vsync <= (cnt < 5'h2);
         vid.hsync <= (cnt[2:0] == 3'h0);
      end
   end
endmodule // cpa_video_src

// file: sim/content_protection_auth_link_check_tb.sv
`timescale 1ns/10ps
module content_protection_auth_link_check_tb;
   localparam int ST_MATCH = 1;
   localparam int ST_KEY = 2;
   localparam int ST_ENH = 3;
   localparam int ST_DONE = 4;
   logic clk;
   logic rst;
   logic [7:0] addr;
   logic [31:0] wdata;
   logic wr;
   logic rd;
   logic [31:0] rdata;
   cpa_pkg::cpa_video_t vid;
   logic [23:0] pix_out;
   logic enc_active;
   logic irq;
   int err_total;
   int checks;
   int diffs;
   logic [63:0] exp_q[$];
   logic [63:0] e;
   logic rd_p1;
   logic plain_chk;
   logic [23:0] pix_p1;
   logic [31:0] val;
   logic [39:0] key;
   logic [15:0] tx;
   logic [7:0] enh;
   logic [39:0] keys [4] = '{40'h00000fffff, 40'h00001fffff, 40'h000007ffff, 40'hf0f0f0f0f0};

   cpa_auth_link_check DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .vid_in(vid), .pix_out(pix_out), .enc_active(enc_active), .irq(irq));
   cpa_video_src SRC (.clk(clk), .rst(rst), .vid(vid));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic fail(input string msg);
      $display("wrong value at %0t: %s", $time, msg);
      err_total++;
   endtask
   task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
      checks++;
      if ((got & msk) !== (exp & msk)) fail("register read");
   endtask
   task automatic cmp_bit(input logic got, input logic exp, input string what);
      checks++;
      if (got !== exp) fail(what);
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_get(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      val = rdata;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
      exp_q.push_back({msk, exp});
      rd_get(a);
   endtask
   task automatic results();
      $display("checks %0d, mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Result monitor: read data one cycle after the strobe, pixels one cycle after input
   always @(posedge clk) begin
      if (rd_p1 && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         cmp_reg(rdata, e[31:0], e[63:32]);
      end
      if (plain_chk) cmp_bit(pix_out === pix_p1, 1'b1, "plain pixel");
      if (enc_active && pix_out !== pix_p1) diffs++;
      rd_p1 <= rd;
      pix_p1 <= vid.pix;
   end

   initial begin
      #200us;
      fail("timeout");
      results();
   end

   initial begin
      addr = 8'h0;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      rst = 1'b1;
      rd_p1 = 1'b0;
      plain_chk = 1'b0;
      err_total = 0;
      checks = 0;
      diffs = 0;
      void'($urandom(32'h3657));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      plain_chk <= 1'b1;
      repeat (64) @(posedge clk);
      plain_chk <= 1'b0;
      $display("test plain data done");
      for (int i = 0; i < 8; i++) begin
         key = (i < 4) ? keys[i] : {8'($urandom), 32'($urandom)};
         wr_reg(cpa_pkg::OFF_KEY_LO, key[31:0]);
         wr_reg(cpa_pkg::OFF_KEY_HI, {24'h0, key[39:32]});
         repeat (4) @(posedge clk);
         rd_chk(cpa_pkg::OFF_STATUS, 32'($countones(key) != 20) << ST_KEY, 32'h1 << ST_KEY);
      end
      $display("test key balance done");
      wr_reg(cpa_pkg::OFF_CTRL, 32'h0);
      wr_reg(cpa_pkg::OFF_CTRL, 32'h1 << cpa_pkg::CTRL_START);
      repeat (cpa_pkg::AUTH_CYCLES - 8) @(posedge clk);
      rd_chk(cpa_pkg::OFF_STATUS, 32'h0, 32'h1 << ST_DONE);
      repeat (12) @(posedge clk);
      rd_chk(cpa_pkg::OFF_STATUS, 32'h1 << ST_DONE, 32'h1 << ST_DONE);
      rd_get(cpa_pkg::OFF_TX_RESP);
      tx = val[15:0];
      wr_reg(cpa_pkg::OFF_RX_RESP, {16'h0, tx});
      rd_chk(cpa_pkg::OFF_RX_RESP, {16'h0, tx}, 32'hffff);
      rd_chk(cpa_pkg::OFF_TX_RESP, {16'h0, tx}, 32'hffff);
      rd_chk(cpa_pkg::OFF_STATUS, 32'h0, 32'h1 << ST_MATCH);
      wr_reg(cpa_pkg::OFF_CTRL, 32'h1);
      wr_reg(cpa_pkg::OFF_RX_RESP, {16'h0, tx ^ 16'h1});
      repeat (4) @(posedge clk);
      rd_chk(cpa_pkg::OFF_STATUS, 32'h0, 32'h1 << ST_MATCH);
      wr_reg(cpa_pkg::OFF_RX_RESP, {16'h0, tx});
      repeat (4) @(posedge clk);
      rd_chk(cpa_pkg::OFF_STATUS, 32'h1 << ST_MATCH, 32'h1 << ST_MATCH);
      wr_reg(cpa_pkg::OFF_CTRL, 32'h1 | (32'h1 << cpa_pkg::CTRL_PROT_RST));
      repeat (4) @(posedge clk);
      rd_chk(cpa_pkg::OFF_STATUS, 32'h0, 32'h1 << ST_MATCH);
      $display("test response compare done");
      // Authenticate again before encryption, frames are counted only while encrypting
      wr_reg(cpa_pkg::OFF_CTRL, 32'h1 << cpa_pkg::CTRL_START);
      repeat (cpa_pkg::AUTH_CYCLES + 8) @(posedge clk);
      wr_reg(cpa_pkg::OFF_CTRL, 32'h1 << cpa_pkg::CTRL_ENC_EN);
      repeat (3 * 32) @(posedge clk);
      cmp_bit(enc_active, 1'b1, "encryption on");
      diffs = 0;
      repeat (64) @(posedge clk);
      cmp_bit(diffs > 0, 1'b1, "cipher output");
      $display("test encryption enable done");
      wr_reg(cpa_pkg::OFF_INT_MASK, 32'h0);
      wr_reg(cpa_pkg::OFF_INT_STAT, 32'hf);
      repeat (17 * 32) @(posedge clk);
      rd_chk(cpa_pkg::OFF_INT_STAT, 32'h1 << cpa_pkg::EV_ENH, 32'h1 << cpa_pkg::EV_ENH);
      cmp_bit(irq, 1'b0, "masked interrupt");
      wr_reg(cpa_pkg::OFF_INT_MASK, 32'h1 << cpa_pkg::EV_ENH);
      repeat (2) @(negedge clk);
      cmp_bit(irq, 1'b1, "unmasked interrupt");
      wr_reg(cpa_pkg::OFF_INT_STAT, 32'h1 << cpa_pkg::EV_ENH);
      repeat (2) @(negedge clk);
      cmp_bit(irq, 1'b0, "cleared interrupt");
      rd_get(cpa_pkg::OFF_ENH);
      enh = val[7:0];
      wr_reg(cpa_pkg::OFF_CTRL, (32'h1 << cpa_pkg::CTRL_ENC_EN) | 32'h1);
      for (int i = 0; i < 3; i++) begin
         wr_reg(cpa_pkg::OFF_ENH, {16'h0, enh ^ 8'(i + 1), 8'h00});
         rd_chk(cpa_pkg::OFF_STATUS, 32'h0, 32'h1 << ST_ENH);
      end
      wr_reg(cpa_pkg::OFF_ENH, {16'h0, enh, 8'h00});
      rd_chk(cpa_pkg::OFF_STATUS, 32'h1 << ST_ENH, 32'h1 << ST_ENH);
      wr_reg(cpa_pkg::OFF_INT_STAT, 32'hf);
      repeat (129 * 32) @(posedge clk);
      rd_chk(cpa_pkg::OFF_INT_STAT, 32'h1 << cpa_pkg::EV_RESP, 32'h1 << cpa_pkg::EV_RESP);
      $display("test periodic responses done");
      wr_reg(cpa_pkg::OFF_CTRL, 32'h0);
      repeat (3 * 32) @(posedge clk);
      cmp_bit(enc_active, 1'b0, "encryption off");
      plain_chk <= 1'b1;
      repeat (64) @(posedge clk);
      plain_chk <= 1'b0;
      $display("test encryption disable done");
      results();
   end
endmodule // content_protection_auth_link_check_tb
